/* dv/dpc_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none

// downstream sink: stalls about half the time so the output buffer fills and drains
module dpc_sink_model (
   input  wire logic clk_sys_in,
   output var  logic ready_out
);
   initial ready_out = 1'b0;

   // random stall pattern, changed just after each rising edge
   always @(posedge clk_sys_in) begin
      ready_out <= ($urandom % 2) != 0;
   end
endmodule

`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"

module testbench;
   import dpc_pkg::*;
   localparam int W = 8;
   localparam int H = 6;
   logic        clk_sys_in   = 1'b0;
   logic        rst_in       = 1'b1;
   logic [7:0]  reg_addr_in  = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   logic        nv_erase_in  = 1'b1;
   logic        pix_valid_in = 1'b0;
   dpc_pix_t    pix_data_in  = 8'h00;
   logic        pix_sof_in   = 1'b0;
   logic        pix_eol_in   = 1'b0;
   logic [31:0] reg_rdata_out;
   logic        pix_ready_out, pix_valid_out, pix_sof_out, pix_eol_out, pix_ready_in;
   dpc_pix_t    pix_data_out;
   int          mismatches   = 0;
   int          check_count  = 0;
   int          cfg_q[$];
   int          base;
   int          ocol = 0, orow = 0, ocfg = -1;
   bit          mon_on = 1'b1;

   always #2 clk_sys_in = ~clk_sys_in;

   dpc_core dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .nv_erase_in(nv_erase_in), .pix_valid_in(pix_valid_in),
      .pix_data_in(pix_data_in), .pix_sof_in(pix_sof_in), .pix_eol_in(pix_eol_in),
      .pix_ready_out(pix_ready_out), .pix_valid_out(pix_valid_out), .pix_data_out(pix_data_out),
      .pix_sof_out(pix_sof_out), .pix_eol_out(pix_eol_out), .pix_ready_in(pix_ready_in));
   dpc_sink_model sink (.clk_sys_in(clk_sys_in), .ready_out(pix_ready_in));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask

   // one-cycle write strobe, launched just after a rising edge
   task automatic reg_wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in   <= 1'b0;
      @(negedge clk_sys_in);
      chk32(n, e, reg_rdata_out);
   endtask

   // write then read back on the very next strobe, no idle cycle between
   task automatic wr_rd_chk(string n, logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in    <= 1'b0;
      reg_rd_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in    <= 1'b0;
      @(negedge clk_sys_in);
      chk32(n, d, reg_rdata_out);
   endtask

   // held until taken; ready sampled mid-cycle where it is settled
   task automatic send_pix(dpc_pix_t v, logic s, logic e);
      bit ok;
      pix_valid_in <= 1'b1;
      pix_data_in  <= v;
      pix_sof_in   <= s;
      pix_eol_in   <= e;
      ok = 1'b0;
      for (int n = 0; n < 1000 && !ok; n++) begin
         @(negedge clk_sys_in);
         ok = pix_ready_out;
         @(posedge clk_sys_in);
      end
      if (!ok) begin
         mismatches++;
         stop_test();
      end
   endtask

   // flat frame with one hot pixel at column 3, row 3
   task automatic send_frame(int flags);
      cfg_q.push_back(base | (flags << 8));
      @(posedge clk_sys_in);
      for (int r = 0; r < H; r++) begin
         for (int c = 0; c < W; c++) begin
            send_pix((r == 3 && c == 3) ? 8'hFF : base[7:0], r == 0 && c == 0, c == W - 1);
         end
      end
      pix_valid_in <= 1'b0;
   endtask

   // output model: position from the markers, value from that frame's setup
   always @(posedge clk_sys_in) begin
      if (mon_on && pix_valid_out === 1'b1 && pix_ready_in === 1'b1) begin
         if (pix_sof_out === 1'b1 && cfg_q.size() > 0) begin
            ocol = 0;
            orow = 0;
            ocfg = cfg_q.pop_front();
         end
         if (ocfg >= 0) begin
            chk8("eol", {7'h0, ocol == W - 1}, {7'h0, pix_eol_out});
            chk8("sof", {7'h0, ocol == 0 && orow == 0}, {7'h0, pix_sof_out});
            chk8("pix", (ocol == 3 && orow == 3 && ocfg[9:8] == 2'b00) ? 8'hFF : ocfg[7:0], pix_data_out);
         end
         if (ocol == W - 1) begin
            ocol = 0;
            orow++;
         end else begin
            ocol++;
         end
      end
   end

   initial begin
      void'($urandom(32'h4D1C));
      base = 16 + ($urandom % 100);
      repeat (5) @(posedge clk_sys_in);
      rst_in      <= 1'b0;
      nv_erase_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rd_chk("ctrl", `DPC_OFS_CTRL, 32'h0);
      reg_wr(`DPC_OFS_CTRL, 32'h0000000F);
      rd_chk("ctrl", `DPC_OFS_CTRL, 32'h3);
      reg_wr(`DPC_OFS_CTRL, 32'h0);
      reg_wr(`DPC_OFS_COUNT, 32'h11);
      rd_chk("count", `DPC_OFS_COUNT, 32'h0);
      rd_chk("unmapped", 8'h1C, 32'h0);
      send_frame(0);
      reg_wr(`DPC_OFS_COUNT, 32'h1);
      reg_wr(`DPC_OFS_SELECT, 32'h0);
      wr_rd_chk("column", `DPC_OFS_COLUMN, 32'h3);
      reg_wr(`DPC_OFS_ROW, 32'h3);
      rd_chk("count", `DPC_OFS_COUNT, 32'h1);
      rd_chk("column", `DPC_OFS_COLUMN, 32'h3);
      rd_chk("row", `DPC_OFS_ROW, 32'h3);
      reg_wr(`DPC_OFS_CTRL, 32'h1);
      send_frame(0);
      reg_wr(`DPC_OFS_CMD, 32'h1);
      rd_chk("status", `DPC_OFS_STATUS, 32'h1);
      send_frame(1);
      rd_chk("status", `DPC_OFS_STATUS, 32'h100);
      reg_wr(`DPC_OFS_CTRL, 32'h2);
      send_frame(2);
      reg_wr(`DPC_OFS_CTRL, 32'h0);
      send_frame(0);
      // entry 1 holds the hot pixel's column 3 but row 0, and lies beyond the count
      reg_wr(`DPC_OFS_COUNT, 32'h2);
      reg_wr(`DPC_OFS_SELECT, 32'h1);
      reg_wr(`DPC_OFS_COLUMN, 32'h3);
      reg_wr(`DPC_OFS_SELECT, 32'h0);
      reg_wr(`DPC_OFS_COLUMN, 32'h5);
      rd_chk("column", `DPC_OFS_COLUMN, 32'h5);
      reg_wr(`DPC_OFS_SELECT, 32'h1);
      rd_chk("column", `DPC_OFS_COLUMN, 32'h3);
      reg_wr(`DPC_OFS_COUNT, 32'h1);
      reg_wr(`DPC_OFS_CTRL, 32'h1);
      reg_wr(`DPC_OFS_CMD, 32'h1);
      send_frame(0);
      reg_wr(`DPC_OFS_CMD, 32'h2);
      rd_chk("cmd", `DPC_OFS_CMD, 32'h0);
      send_frame(0);
      // power cycle without erase: stored table must come back
      mon_on = 1'b0;
      @(posedge clk_sys_in);
      rst_in <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rd_chk("count", `DPC_OFS_COUNT, 32'h1);
      rd_chk("status", `DPC_OFS_STATUS, 32'h100);
      reg_wr(`DPC_OFS_SELECT, 32'h0);
      rd_chk("column", `DPC_OFS_COLUMN, 32'h5);
      stop_test();
   end
endmodule

`default_nettype wire

/* rtl/dpc_core.sv */
// Function
// - table correction only while table enable set
// - outlier correction has its own enable
// - only method offered is neighbour averaging
// - host reads and writes the entry count
// - selector picks element for column/row access
// - column accessor reads/writes selected staged entry
// - row accessor reads/writes selected staged entry
// - edits invisible until commit
// - commit copies staged table to working table
// - persist overwrites non-volatile table entirely
// - power-up loads non-volatile table as active
// - coordinates relative to full sensor frame
// - selector is zero-based
// - outliers in 5x5 window are clamped
// - listed pixel becomes mean of neighbours
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"

module dpc_core (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_in,
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic [31:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic [31:0]                reg_rdata_out,
   input  wire logic                  nv_erase_in,
   input  wire logic                  pix_valid_in,
   input  wire dpc_pkg::dpc_pix_t     pix_data_in,
   input  wire logic                  pix_sof_in,
   input  wire logic                  pix_eol_in,
   output logic                       pix_ready_out,
   output logic                       pix_valid_out,
   output dpc_pkg::dpc_pix_t          pix_data_out,
   output logic                       pix_sof_out,
   output logic                       pix_eol_out,
   input  wire logic                  pix_ready_in
);
   import dpc_pkg::*;

   localparam int NE = `DPC_ENTRIES;
   localparam int CW = `DPC_COORD_W;

   // control and table state
   logic        tbl_on_r;
   logic        dyn_on_r;
   dpc_method_t method_r;
   dpc_cnt_t    stg_cnt_r;
   dpc_cnt_t    wrk_cnt_r;
   logic [3:0]  sel_r;
   dpc_coord_t  stg_col_r [0:NE-1];
   dpc_coord_t  stg_row_r [0:NE-1];
   dpc_coord_t  wrk_col_r [0:NE-1];
   dpc_coord_t  wrk_row_r [0:NE-1];
   logic        commit_pend_r;
   dpc_boot_t   boot_st_r;
   logic [31:0] rdata_r;
   // non-volatile side
   dpc_cnt_t    nv_cnt;
   dpc_flat_t   nv_col_flat;
   dpc_flat_t   nv_row_flat;
   dpc_flat_t   stg_col_flat;
   dpc_flat_t   stg_row_flat;
   logic        persist_go;
   // stream pipeline
   dpc_word_t   lmem [0:`DPC_LINES-1][0:`DPC_MAX_COLS-1];
   dpc_word_t   win_r [0:`DPC_WIN-1][0:`DPC_WIN-1];
   dpc_word_t   colvec [0:`DPC_WIN-1];
   dpc_word_t   in_word;
   dpc_coord_t  col_r;
   dpc_coord_t  row_r;
   dpc_coord_t  cpos;
   dpc_coord_t  rpos;
   dpc_coord_t  ctr_col_r;
   dpc_coord_t  ctr_row_r;
   logic        ring_ok_r;
   logic        full_ok_r;
   logic        s1_valid_r;
   logic        accept;
   logic        buf_ready;
   logic        push;
   logic        hit;
   dpc_pix_t    ctr_pix;
   dpc_pix_t    avg_pix;
   dpc_pix_t    nmax;
   dpc_pix_t    nmin;
   dpc_pix_t    res_pix;
   dpc_word_t   buf_word;
   logic        wr_ctrl;
   logic        wr_cmd;

   // slice one coordinate out of a flat table image
   function automatic dpc_coord_t flat_coord(input dpc_flat_t flat, input int idx);
      flat_coord = flat[idx*CW +: CW];
   endfunction

   assign wr_ctrl    = reg_wr_in && (reg_addr_in == `DPC_OFS_CTRL);
   assign wr_cmd     = reg_wr_in && (reg_addr_in == `DPC_OFS_CMD);
   assign persist_go = wr_cmd && reg_wdata_in[`DPC_CMD_PERSIST];

   // control bits; any method code other than average is refused
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         tbl_on_r <= `DPC_RST_TBL_ON;
         dyn_on_r <= `DPC_RST_DYN_ON;
         method_r <= DPC_METHOD_AVERAGE;
      end else if (wr_ctrl) begin
         tbl_on_r <= reg_wdata_in[`DPC_CTRL_TBL_BIT];
         dyn_on_r <= reg_wdata_in[`DPC_CTRL_DYN_BIT];
         method_r <= DPC_METHOD_AVERAGE;
      end
   end

   // boot sequencer: one cycle after reset the stored table becomes active
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         boot_st_r <= DPC_BOOT;
      end else begin
         unique case (boot_st_r)
            DPC_BOOT: boot_st_r <= DPC_RUN;
            DPC_RUN:  boot_st_r <= DPC_RUN;
         endcase
      end
   end

   // entry count and zero-based selector
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         stg_cnt_r <= '0;
         sel_r     <= '0;
      end else if (boot_st_r == DPC_BOOT) begin
         stg_cnt_r <= nv_cnt;
      end else if (reg_wr_in) begin
         // counts above capacity are ignored
         if (reg_addr_in == `DPC_OFS_COUNT && reg_wdata_in <= 32'(NE)) begin
            stg_cnt_r <= reg_wdata_in[`DPC_CNT_W-1:0];
         end
         if (reg_addr_in == `DPC_OFS_SELECT) begin
            sel_r <= reg_wdata_in[`DPC_IDX_W-1:0];
         end
      end
   end

   // staged table: accessor writes touch the selected element only
   always_ff @(posedge clk_sys_in) begin
      if (boot_st_r == DPC_BOOT) begin
         for (int i = 0; i < NE; i++) begin
            stg_col_r[i] <= flat_coord(nv_col_flat, i);
            stg_row_r[i] <= flat_coord(nv_row_flat, i);
         end
      end else if (reg_wr_in && reg_addr_in == `DPC_OFS_COLUMN) begin
         stg_col_r[sel_r] <= reg_wdata_in[CW-1:0];
      end else if (reg_wr_in && reg_addr_in == `DPC_OFS_ROW) begin
         stg_row_r[sel_r] <= reg_wdata_in[CW-1:0];
      end
   end

   // commit request waits for a frame start; a new request beats the clear
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         commit_pend_r <= 1'b0;
      end else if (wr_cmd && reg_wdata_in[`DPC_CMD_COMMIT]) begin
         commit_pend_r <= 1'b1;
      end else if (accept && pix_sof_in) begin
         commit_pend_r <= 1'b0;
      end
   end

   // working table, volatile: lost with the reset, refilled from storage
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wrk_cnt_r <= '0;
      end else if (boot_st_r == DPC_BOOT) begin
         wrk_cnt_r <= nv_cnt;
      end else if (commit_pend_r && accept && pix_sof_in) begin
         wrk_cnt_r <= stg_cnt_r;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (boot_st_r == DPC_BOOT) begin
         for (int i = 0; i < NE; i++) begin
            wrk_col_r[i] <= flat_coord(nv_col_flat, i);
            wrk_row_r[i] <= flat_coord(nv_row_flat, i);
         end
      end else if (commit_pend_r && accept && pix_sof_in) begin
         // copy at frame start so no frame mixes two tables
         for (int i = 0; i < NE; i++) begin
            wrk_col_r[i] <= stg_col_r[i];
            wrk_row_r[i] <= stg_row_r[i];
         end
      end
   end

   // flatten the staged table for the persist path
   always_comb begin
      stg_col_flat = '0;
      stg_row_flat = '0;
      for (int i = 0; i < NE; i++) begin
         stg_col_flat[i*CW +: CW] = stg_col_r[i];
         stg_row_flat[i*CW +: CW] = stg_row_r[i];
      end
   end

   dpc_nvstore u_nvstore (
      .clk_sys_in   (clk_sys_in),
      .erase_in     (nv_erase_in),
      .persist_in   (persist_go),
      .cnt_in       (stg_cnt_r),
      .col_flat_in  (stg_col_flat),
      .row_flat_in  (stg_row_flat),
      .cnt_out      (nv_cnt),
      .col_flat_out (nv_col_flat),
      .row_flat_out (nv_row_flat)
   );

   // register read path, data valid the cycle after the strobe only
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !reg_rd_in) begin
         rdata_r <= '0;
      end else begin
         unique case (reg_addr_in)
            `DPC_OFS_CTRL:   rdata_r <= {28'h0, method_r, dyn_on_r, tbl_on_r};
            `DPC_OFS_COUNT:  rdata_r <= {27'h0, stg_cnt_r};
            `DPC_OFS_SELECT: rdata_r <= {28'h0, sel_r};
            `DPC_OFS_COLUMN: rdata_r <= {20'h0, stg_col_r[sel_r]};
            `DPC_OFS_ROW:    rdata_r <= {20'h0, stg_row_r[sel_r]};
            `DPC_OFS_STATUS: rdata_r <= {19'h0, wrk_cnt_r, 6'h0, boot_st_r == DPC_BOOT, commit_pend_r};
            default:         rdata_r <= '0;
         endcase
      end
   end
   assign reg_rdata_out = rdata_r;

   // stream control: input stalls while the window stage cannot drain
   assign pix_ready_out = (boot_st_r == DPC_RUN) && (!s1_valid_r || buf_ready);
   assign accept        = pix_valid_in && pix_ready_out;
   assign push          = s1_valid_r && buf_ready;
   assign cpos          = pix_sof_in ? '0 : col_r;
   assign rpos          = pix_sof_in ? '0 : row_r;
   assign in_word       = {pix_sof_in, pix_eol_in, pix_data_in};

   // column of five vertically stacked pixels at the input column
   always_comb begin
      colvec[0] = in_word;
      for (int k = 1; k < `DPC_WIN; k++) begin
         colvec[k] = lmem[k-1][cpos[`DPC_COL_IDX_W-1:0]];
      end
   end

   // line memories keep marker bits so the centre keeps its own frame markers
   // cleared in reset so the first frame's border windows hold no stale markers
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         for (int k = 0; k < `DPC_LINES; k++) begin
            for (int j = 0; j < `DPC_MAX_COLS; j++) begin
               lmem[k][j] <= '0;
            end
         end
      end else if (accept) begin
         for (int k = 0; k < `DPC_LINES; k++) begin
            lmem[k][cpos[`DPC_COL_IDX_W-1:0]] <= colvec[k];
         end
      end
   end

   // full-frame position counters, no region offset applied
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         col_r     <= '0;
         row_r     <= '0;
         ctr_col_r <= '0;
         ctr_row_r <= '0;
         ring_ok_r <= 1'b0;
         full_ok_r <= 1'b0;
      end else if (accept) begin
         col_r     <= pix_eol_in ? '0 : cpos + 12'h001;
         row_r     <= pix_eol_in ? rpos + 12'h001 : rpos;
         ctr_col_r <= cpos - 12'h002;
         ctr_row_r <= rpos - 12'h002;
         ring_ok_r <= (cpos >= 12'h003) && (rpos >= 12'h003);
         full_ok_r <= (cpos >= 12'h004) && (rpos >= 12'h004);
      end
   end

   // window shift, newest column at index 0
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         for (int r = 0; r < `DPC_WIN; r++) begin
            for (int c = 0; c < `DPC_WIN; c++) begin
               win_r[r][c] <= '0;
            end
         end
      end else if (accept) begin
         for (int r = 0; r < `DPC_WIN; r++) begin
            win_r[r][0] <= colvec[r];
            for (int c = 1; c < `DPC_WIN; c++) begin
               win_r[r][c] <= win_r[r][c-1];
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s1_valid_r <= 1'b0;
      end else if (accept) begin
         s1_valid_r <= 1'b1;
      end else if (push) begin
         s1_valid_r <= 1'b0;
      end
   end

   // table lookup against committed entries below the count
   always_comb begin
      hit = 1'b0;
      for (int i = 0; i < NE; i++) begin
         if (5'(i) < wrk_cnt_r && wrk_col_r[i] == ctr_col_r && wrk_row_r[i] == ctr_row_r) begin
            hit = 1'b1;
         end
      end
   end

   // neighbour mean over the eight pixels of the inner ring
   always_comb begin
      logic [10:0] sum;
      sum = '0;
      for (int r = 1; r < 4; r++) begin
         for (int c = 1; c < 4; c++) begin
            if (!(r == 2 && c == 2)) begin
               sum = sum + {3'h0, win_r[r][c][`DPC_PIX_W-1:0]};
            end
         end
      end
      avg_pix = sum[10:3];
   end

   // extremes of the 24 surrounding pixels
   always_comb begin
      nmax = '0;
      nmin = '1;
      for (int r = 0; r < `DPC_WIN; r++) begin
         for (int c = 0; c < `DPC_WIN; c++) begin
            if (!(r == 2 && c == 2)) begin
               if (win_r[r][c][`DPC_PIX_W-1:0] > nmax) begin
                  nmax = win_r[r][c][`DPC_PIX_W-1:0];
               end
               if (win_r[r][c][`DPC_PIX_W-1:0] < nmin) begin
                  nmin = win_r[r][c][`DPC_PIX_W-1:0];
               end
            end
         end
      end
   end

   // table replacement wins; borders are left untouched
   assign ctr_pix = win_r[2][2][`DPC_PIX_W-1:0];
   always_comb begin
      res_pix = ctr_pix;
      if (tbl_on_r && hit && ring_ok_r && method_r == DPC_METHOD_AVERAGE) begin
         res_pix = avg_pix;
      end else if (dyn_on_r && full_ok_r) begin
         if (ctr_pix > nmax) begin
            res_pix = nmax;
         end else if (ctr_pix < nmin) begin
            res_pix = nmin;
         end
      end
   end
   assign buf_word = {win_r[2][2][`DPC_SOF_BIT], win_r[2][2][`DPC_EOL_BIT], res_pix};

   dpc_word_t out_word;
   dpc_skid u_skid (
      .clk_sys_in    (clk_sys_in),
      .rst_in        (rst_in),
      .in_valid_in   (s1_valid_r),
      .in_data_in    (buf_word),
      .in_ready_out  (buf_ready),
      .out_valid_out (pix_valid_out),
      .out_data_out  (out_word),
      .out_ready_in  (pix_ready_in)
   );
   assign pix_data_out = out_word[`DPC_PIX_W-1:0];
   assign pix_eol_out  = out_word[`DPC_EOL_BIT];
   assign pix_sof_out  = out_word[`DPC_SOF_BIT];

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   AST_TBL_OFF_PASS: assert property (s1_valid_r && !tbl_on_r && !dyn_on_r |-> res_pix == ctr_pix)
      else $error("pixel altered with both corrections off");
   AST_TBL_AVG: assert property (s1_valid_r && tbl_on_r && hit && ring_ok_r |-> res_pix == avg_pix)
      else $error("listed pixel not replaced by neighbour mean");
   AST_DYN_HOT: assert property (s1_valid_r && dyn_on_r && !(tbl_on_r && hit) && full_ok_r && ctr_pix > nmax
                                 |-> res_pix == nmax)
      else $error("hot outlier not clamped");
   AST_DYN_OFF: assert property (s1_valid_r && !dyn_on_r && !(tbl_on_r && hit) |-> res_pix == ctr_pix)
      else $error("outlier correction acted while disabled");
   AST_EDIT_HIDDEN: assert property (reg_wr_in && reg_addr_in == `DPC_OFS_COLUMN && !(commit_pend_r && accept)
                                     |=> wrk_col_r[$past(sel_r)] == $past(wrk_col_r[sel_r]))
      else $error("column edit reached working table");
   AST_COMMIT_SOF: assert property (commit_pend_r && accept && pix_sof_in && !wr_cmd
                                    |=> !commit_pend_r && wrk_cnt_r == $past(stg_cnt_r))
      else $error("commit not applied at frame start");
   AST_COL_READBACK: assert property (reg_wr_in && reg_addr_in == `DPC_OFS_COLUMN
                                      ##1 reg_rd_in && reg_addr_in == `DPC_OFS_COLUMN && $stable(sel_r)
                                      |=> reg_rdata_out[CW-1:0] == $past(reg_wdata_in[CW-1:0], 2))
      else $error("column readback mismatch");
   AST_ROW_WRITE: assert property (reg_wr_in && reg_addr_in == `DPC_OFS_ROW && boot_st_r == DPC_RUN
                                   |=> stg_row_r[$past(sel_r)] == $past(reg_wdata_in[CW-1:0]))
      else $error("row write not stored at selected entry");
   AST_COUNT_RW: assert property (reg_wr_in && reg_addr_in == `DPC_OFS_COUNT && reg_wdata_in <= 32'(NE)
                                  && boot_st_r == DPC_RUN |=> stg_cnt_r == $past(reg_wdata_in[4:0]))
      else $error("entry count write lost");
   AST_PERSIST: assert property (persist_go && !nv_erase_in |=> nv_cnt == $past(stg_cnt_r)
                                 && nv_col_flat == $past(stg_col_flat))
      else $error("persist did not overwrite stored table");
   AST_BOOT_LOAD: assert property (boot_st_r == DPC_BOOT |=> wrk_cnt_r == $past(nv_cnt)
                                   && stg_cnt_r == $past(nv_cnt))
      else $error("stored table not loaded at power-up");

   COV_COMMIT: cover property (commit_pend_r && accept && pix_sof_in);
   COV_TBL_HIT: cover property (push && tbl_on_r && hit && ring_ok_r);
   COV_OUTLIER: cover property (push && dyn_on_r && full_ok_r && ctr_pix > nmax);
   COV_BUF_FULL: cover property (s1_valid_r && !buf_ready);
endmodule

`default_nettype wire

/* rtl/dpc_nvstore.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"

module dpc_nvstore (
   input  wire logic                  clk_sys_in,
   input  wire logic                  erase_in,
   input  wire logic                  persist_in,
   input  wire dpc_pkg::dpc_cnt_t     cnt_in,
   input  wire dpc_pkg::dpc_flat_t    col_flat_in,
   input  wire dpc_pkg::dpc_flat_t    row_flat_in,
   output dpc_pkg::dpc_cnt_t          cnt_out,
   output dpc_pkg::dpc_flat_t         col_flat_out,
   output dpc_pkg::dpc_flat_t         row_flat_out
);
   import dpc_pkg::*;

   // deliberately outside the system reset: contents must outlive it
   always_ff @(posedge clk_sys_in) begin
      if (erase_in) begin
         cnt_out <= '0;
      end else if (persist_in) begin
         cnt_out <= cnt_in;
      end
   end

   // whole table overwritten in one go, never merged; erase blanks coordinates too
   always_ff @(posedge clk_sys_in) begin
      if (erase_in) begin
         col_flat_out <= '0;
         row_flat_out <= '0;
      end else if (persist_in) begin
         col_flat_out <= col_flat_in;
         row_flat_out <= row_flat_in;
      end
   end
endmodule

`default_nettype wire

/* rtl/dpc_pkg.sv */
`include "dpc_regs.svh"

package dpc_pkg;
   typedef logic [`DPC_PIX_W-1:0]   dpc_pix_t;
   typedef logic [`DPC_WORD_W-1:0]  dpc_word_t;
   typedef logic [`DPC_COORD_W-1:0] dpc_coord_t;
   typedef logic [`DPC_FLAT_W-1:0]  dpc_flat_t;
   typedef logic [`DPC_CNT_W-1:0]   dpc_cnt_t;
   typedef enum logic [1:0] {DPC_METHOD_AVERAGE} dpc_method_t;
   typedef enum logic {DPC_BOOT, DPC_RUN} dpc_boot_t;
endpackage

/* rtl/dpc_regs.svh */
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// pixel stream geometry
`define DPC_PIX_W        8
`define DPC_WORD_W       10
`define DPC_EOL_BIT      8
`define DPC_SOF_BIT      9
`define DPC_MAX_COLS     1024
`define DPC_COL_IDX_W    10
`define DPC_LINES        4
`define DPC_WIN          5

// defect table geometry
`define DPC_COORD_W      12
`define DPC_ENTRIES      16
`define DPC_IDX_W        4
`define DPC_CNT_W        5
`define DPC_FLAT_W       192

// register bus
`define DPC_ADDR_W       8
`define DPC_DATA_W       32
`define DPC_OFS_CTRL     8'h00
`define DPC_OFS_COUNT    8'h04
`define DPC_OFS_SELECT   8'h08
`define DPC_OFS_COLUMN   8'h0C
`define DPC_OFS_ROW      8'h10
`define DPC_OFS_CMD      8'h14
`define DPC_OFS_STATUS   8'h18

// field positions
`define DPC_CTRL_TBL_BIT 0
`define DPC_CTRL_DYN_BIT 1
`define DPC_CTRL_MTH_LSB 2
`define DPC_CMD_COMMIT   0
`define DPC_CMD_PERSIST  1
`define DPC_ST_PEND_BIT  0
`define DPC_ST_BOOT_BIT  1
`define DPC_ST_WCNT_LSB  8

// reset values
`define DPC_RST_TBL_ON   1'b0
`define DPC_RST_DYN_ON   1'b0

`endif

/* rtl/dpc_skid.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"

module dpc_skid (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_in,
   input  wire logic                  in_valid_in,
   input  wire dpc_pkg::dpc_word_t    in_data_in,
   output logic                       in_ready_out,
   output logic                       out_valid_out,
   output dpc_pkg::dpc_word_t         out_data_out,
   input  wire logic                  out_ready_in
);
   import dpc_pkg::*;

   dpc_word_t  mem_r [0:1];
   logic       wp_r;
   logic       rp_r;
   logic [1:0] fill_r;
   logic       push;
   logic       pop;

   // two entries so a stalled receiver never drops a word
   assign in_ready_out  = (fill_r != 2'h2);
   assign out_valid_out = (fill_r != 2'h0);
   assign out_data_out  = mem_r[rp_r];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // storage has no reset, only pointers and fill level do
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem_r[wp_r] <= in_data_in;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wp_r   <= 1'b0;
         rp_r   <= 1'b0;
         fill_r <= 2'h0;
      end else begin
         if (push) begin
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

`default_nettype wire
